// ==== logic/wwd_pkg.sv ====
// Purpose: Constants, state codes and helpers for the window watchdog
// Assumes: 200 MHz core clock, all windows counted in 0.5 ms ticks
// Notes: Operation summary follows
package wwd_pkg;
   // Clock rate and sampling period
   localparam int CLK_MHZ = 200;
   localparam int T_SAM_US = 500;
   localparam int SAM_CYCLES = T_SAM_US * CLK_MHZ;
   localparam int US_PER_MS = 1000;
   // Nominal durations in ms, window lengths given for fast timing
   localparam int T_RD_FAST_MS = 16;
   localparam int T_RD_SLOW_MS = 32;
   localparam int T_IW_MS = 32;
   localparam int T_CW_MS = 32;
   localparam int T_OW_MS = 32;
   localparam int LONG_OW_MULT = 4;
   localparam int SLOW_MULT = 2;
   // Window counter
   localparam int CNT_W = 10;
   localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
   // Trigger sample history
   localparam int HIST_W = 4;
   localparam logic [HIST_W-1:0] TRIG_PATTERN = 4'hC;
   localparam logic [HIST_W-2:0] HIST_CLEAR = 3'h0;
   // Register port
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_CAUSE = 8'h04;
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_SLOW_BIT = 3;
   localparam int STAT_OFF_BIT = 4;
   localparam int STAT_RST_BIT = 5;
   localparam int STAT_SUSP_BIT = 6;
   localparam int CAUSE_W = 3;
   localparam int CAUSE_MISS_BIT = 0;
   localparam int CAUSE_EARLY_BIT = 1;
   localparam int CAUSE_UV_BIT = 2;
   localparam logic [CAUSE_W-1:0] CAUSE_RESET = 3'h0;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
   // Window states, Gray along the usual path
   typedef enum logic [2:0] {
      ST_RESET = 3'h0,
      ST_IGNORE = 3'h1,
      ST_LONG = 3'h3,
      ST_CLOSED = 3'h2,
      ST_OPEN = 3'h6,
      ST_OFF = 3'h7
   } wd_state_t;
   // Window length in ticks, doubled for slow timing
   function automatic logic [CNT_W-1:0] win_ticks(input int ms, input logic slow);
      int t;
      t = ms * US_PER_MS / T_SAM_US;
      if (slow)
      begin
         t = t * SLOW_MULT;
      end
      return t[CNT_W-1:0];
   endfunction
endpackage

// ==== logic/wwd_timebase.sv ====
// Purpose: Free-running sample tick for all watchdog timing
// Assumes: Period given in core clock cycles
// Notes: Tick is a one-cycle pulse from a flip-flop
`timescale 1ns/1ps
module wwd_timebase
   import wwd_pkg::*;
#(
   parameter int PERIOD = SAM_CYCLES
)(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   output logic tick_q
);
   // Counter width from the period
   localparam int TW = $clog2(PERIOD + 1);
   localparam logic [TW-1:0] LAST = TW'(PERIOD - 1);
   localparam logic [TW-1:0] ONE = TW'(1);
   localparam logic [TW-1:0] ZERO = TW'(0);

   logic [TW-1:0] div_q; // Cycle divider

   // Divider wraps once per sample period
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         div_q <= ZERO;
         tick_q <= 1'b0;
      end
      else if (clk_en)
      begin
         // One tick per wrap
         if (div_q == LAST)
         begin
            div_q <= ZERO;
            tick_q <= 1'b1;
         end
         else
         begin
            div_q <= div_q + ONE;
            tick_q <= 1'b0;
         end
      end
   end
endmodule

// ==== logic/window_watchdog_reset.sv ====
// Purpose: Window watchdog and reset generator for a regulator
// Assumes: Straps static, comparator flags synchronous to core_clk
// Notes: Clock enable low freezes every flip-flop, register port too
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module window_watchdog_reset
   import wwd_pkg::*;
#(
   parameter int SAMPLE_PERIOD = SAM_CYCLES
)(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic wd_trigger_in,
   input wire logic mode_sel_1,
   input wire logic mode_sel_2,
   input wire logic uv_out,
   input wire logic uv_in,
   input wire logic uv_in_enable,
   input wire logic low_load,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   output logic reset_out_n
);
   // Sequencer state
   wd_state_t state_q; // Current window
   wd_state_t state_d; // Next window
   logic [CNT_W-1:0] cnt_q; // Ticks spent in window
   logic [CNT_W-1:0] cnt_d;
   logic [CNT_W-1:0] limit; // Length of current window
   logic expire; // Last tick of window
   logic tick_q; // Sample tick
   // Mode straps, registered
   logic slow_q; // Slow window timing
   logic wd_off_q; // Watchdog disabled
   logic rd_slow_q; // Slow reset delay
   logic [CNT_W-1:0] rd_ticks; // Reset delay length
   // Trigger sampler
   logic [HIST_W-2:0] hist_q; // Last three samples
   logic armed; // Trigger counts in this state
   logic trig_valid; // Valid trigger this cycle
   // Supervision
   logic uv_any; // Any undervoltage
   logic wd_active; // Watchdog running
   logic miss_ev; // Missing pulse reset
   logic early_ev; // Premature pulse reset
   logic uv_ev; // Undervoltage reset
   // Registers
   logic [CAUSE_W-1:0] cause_q; // Sticky reset causes
   logic [CAUSE_W-1:0] cause_clr;
   logic [CAUSE_W-1:0] cause_set;
   logic [DATA_W-1:0] rdata_q;
   logic rst_out_q;

   // Strap decoder: window timing is slow
   function automatic logic strap_slow(input logic m1, input logic m2);
      return !m1 && m2;
   endfunction

   // Strap decoder: watchdog disabled
   function automatic logic strap_off(input logic m1, input logic m2);
      return m1 && m2;
   endfunction

   // Sample tick source
   wwd_timebase #(
      .PERIOD(SAMPLE_PERIOD)
   ) u_timebase (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .tick_q(tick_q)
   );

   // Register the mode straps
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         slow_q <= 1'b0;
         wd_off_q <= 1'b0;
         rd_slow_q <= 1'b0;
      end
      else if (clk_en)
      begin
         // Timing and off decode
         slow_q <= strap_slow(mode_sel_1, mode_sel_2);
         wd_off_q <= strap_off(mode_sel_1, mode_sel_2);
         // Fast delay only with both low
         rd_slow_q <= mode_sel_1 || mode_sel_2;
      end
   end

   // Undervoltage and suspend qualifiers
   always_comb
   begin
      // Output flag always, input flag on low-voltage parts
      uv_any = uv_out || (uv_in && uv_in_enable);
      // Low load suspends watchdog
      wd_active = !wd_off_q && !low_load;
   end

   // Window length for current state
   always_comb
   begin
      rd_ticks = rd_slow_q ? win_ticks(T_RD_SLOW_MS, 1'b0) : win_ticks(T_RD_FAST_MS, 1'b0);
      case (state_q)
         ST_RESET: limit = rd_ticks;
         ST_IGNORE: limit = win_ticks(T_IW_MS, slow_q);
         ST_LONG: limit = win_ticks(T_OW_MS * LONG_OW_MULT, slow_q);
         ST_CLOSED: limit = win_ticks(T_CW_MS, slow_q);
         ST_OPEN: limit = win_ticks(T_OW_MS, slow_q);
         default: limit = win_ticks(T_OW_MS, slow_q);
      endcase
      // Window ends on its last tick
      expire = tick_q && (cnt_q == limit - CNT_ONE);
   end

   // Trigger history sampled once per tick
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         hist_q <= HIST_CLEAR;
      end
      else if (clk_en)
      begin
         // Ignored outside watchdog windows
         if (!armed)
         begin
            hist_q <= HIST_CLEAR;
         end
         // Shift in one sample per period
         else if (tick_q)
         begin
            hist_q <= {hist_q[HIST_W-3:0], wd_trigger_in};
         end
      end
   end

   // Trigger decoder
   always_comb
   begin
      armed = (state_q == ST_LONG) || (state_q == ST_CLOSED) || (state_q == ST_OPEN);
      // High, high, low, low: a falling edge
      trig_valid = armed && tick_q && ({hist_q, wd_trigger_in} == TRIG_PATTERN);
   end

   // Window sequencer next state
   always_comb
   begin
      state_d = state_q;
      miss_ev = 1'b0;
      early_ev = 1'b0;
      case (state_q)
         // Hold reset for the delay
         ST_RESET:
         begin
            if (expire)
            begin
               // Release starts ignore window, or off window when the watchdog is inactive
               state_d = wd_active ? ST_IGNORE : ST_OFF;
            end
         end
         // Trigger ignored here
         ST_IGNORE:
         begin
            if (expire)
            begin
               state_d = ST_LONG;
            end
         end
         // First trigger awaited
         ST_LONG:
         begin
            if (trig_valid)
            begin
               state_d = ST_CLOSED;
            end
            else if (expire)
            begin
               // Pattern must finish in time
               state_d = ST_RESET;
               miss_ev = 1'b1;
            end
         end
         // Trigger here is premature
         ST_CLOSED:
         begin
            if (trig_valid)
            begin
               state_d = ST_RESET;
               early_ev = 1'b1;
            end
            else if (expire)
            begin
               state_d = ST_OPEN;
            end
         end
         // Trigger expected here
         ST_OPEN:
         begin
            if (trig_valid)
            begin
               state_d = ST_CLOSED;
            end
            else if (expire)
            begin
               state_d = ST_RESET;
               miss_ev = 1'b1;
            end
         end
         // Disabled or suspended
         ST_OFF:
         begin
            if (wd_active)
            begin
               state_d = ST_IGNORE;
            end
         end
         default:
         begin
            state_d = ST_RESET;
         end
      endcase
      // Suspend or disable outside the delay
      if (!wd_active && (state_q != ST_RESET))
      begin
         state_d = ST_OFF;
         miss_ev = 1'b0;
         early_ev = 1'b0;
      end
      // Undervoltage wins over all
      uv_ev = uv_any && (state_q != ST_RESET);
      if (uv_any)
      begin
         state_d = ST_RESET;
      end
   end

   // Counter restarts with each window
   always_comb
   begin
      if (uv_any || (state_d != state_q))
      begin
         // Fresh full sequence after any reset
         cnt_d = CNT_ZERO;
      end
      else if (tick_q && (state_q != ST_OFF))
      begin
         cnt_d = cnt_q + CNT_ONE;
      end
      else
      begin
         cnt_d = cnt_q;
      end
   end

   // Sequencer and reset output flops
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state_q <= ST_RESET;
         cnt_q <= CNT_ZERO;
         rst_out_q <= 1'b0;
      end
      else if (clk_en)
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         // Low through the whole delay
         rst_out_q <= (state_d != ST_RESET);
      end
   end

   // Sticky reset causes, set beats clear
   always_comb
   begin
      cause_clr = CAUSE_RESET;
      if (reg_wr && (reg_addr == OFF_CAUSE))
      begin
         cause_clr = reg_wdata[CAUSE_W-1:0];
      end
      cause_set = CAUSE_RESET;
      cause_set[CAUSE_MISS_BIT] = miss_ev;
      cause_set[CAUSE_EARLY_BIT] = early_ev;
      cause_set[CAUSE_UV_BIT] = uv_ev;
   end

   // Cause register
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         cause_q <= CAUSE_RESET;
      end
      else if (clk_en)
      begin
         cause_q <= (cause_q & ~cause_clr) | cause_set;
      end
   end

   // Read data, valid the cycle after a read only
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         rdata_q <= DATA_ZERO;
      end
      else if (clk_en)
      begin
         rdata_q <= DATA_ZERO;
         if (reg_rd)
         begin
            case (reg_addr)
               // Live window state and mode
               OFF_STATUS:
               begin
                  rdata_q[STAT_STATE_LSB +: $bits(wd_state_t)] <= state_q;
                  rdata_q[STAT_SLOW_BIT] <= slow_q;
                  rdata_q[STAT_OFF_BIT] <= wd_off_q;
                  rdata_q[STAT_RST_BIT] <= rst_out_q;
                  rdata_q[STAT_SUSP_BIT] <= low_load;
               end
               // Sticky causes
               OFF_CAUSE:
               begin
                  rdata_q[CAUSE_W-1:0] <= cause_q;
               end
               // Unmapped reads zero
               default:
               begin
                  rdata_q <= DATA_ZERO;
               end
            endcase
         end
      end
   end

   assign reg_rdata = rdata_q;
   assign reset_out_n = rst_out_q;

   // Qualifier shared by the checks below
   logic run;
   assign run = clk_en && !uv_any && wd_active;

   sequence s_long_trig;
      (state_q == ST_LONG) && run && trig_valid;
   endsequence

   sequence s_closed_trig;
      (state_q == ST_CLOSED) && run && trig_valid;
   endsequence

   sequence s_open_trig;
      (state_q == ST_OPEN) && run && trig_valid;
   endsequence

   sequence s_open_expire;
      (state_q == ST_OPEN) && run && expire && !trig_valid;
   endsequence

   property p_rd_hold;
      @(posedge core_clk) disable iff (sys_rst)
      $rose(rst_out_q) |-> ($past(cnt_q) == rd_ticks - CNT_ONE);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("reset released early");

   property p_ignore_start;
      @(posedge core_clk) disable iff (sys_rst)
      ($rose(rst_out_q) && wd_active) |-> (state_q == ST_IGNORE) && (cnt_q == CNT_ZERO);
   endproperty
   a_ignore_start: assert property (p_ignore_start) else $error("no ignore window");

   property p_long_start;
      @(posedge core_clk) disable iff (sys_rst)
      ((state_q == ST_IGNORE) && run && expire) |=> (state_q == ST_LONG) && armed;
   endproperty
   a_long_start: assert property (p_long_start) else $error("no long window");

   property p_long_trig;
      @(posedge core_clk) disable iff (sys_rst)
      s_long_trig |=> (state_q == ST_CLOSED) && (cnt_q == CNT_ZERO) && rst_out_q;
   endproperty
   a_long_trig: assert property (p_long_trig) else $error("closed not started");

   property p_falling;
      @(posedge core_clk) disable iff (sys_rst)
      trig_valid |-> !wd_trigger_in && hist_q[1] && !hist_q[0];
   endproperty
   a_falling: assert property (p_falling) else $error("trigger not a fall");

   property p_pattern;
      @(posedge core_clk) disable iff (sys_rst)
      trig_valid |-> tick_q && (hist_q == TRIG_PATTERN[HIST_W-1:1]) && $past(armed);
   endproperty
   a_pattern: assert property (p_pattern) else $error("bad sample pattern");

   property p_open_start;
      @(posedge core_clk) disable iff (sys_rst)
      ((state_q == ST_CLOSED) && run && expire && !trig_valid) |=> (state_q == ST_OPEN);
   endproperty
   a_open_start: assert property (p_open_start) else $error("open not started");

   property p_open_trig;
      @(posedge core_clk) disable iff (sys_rst)
      s_open_trig |=> (state_q == ST_CLOSED) && rst_out_q;
   endproperty
   a_open_trig: assert property (p_open_trig) else $error("open not ended");

   property p_missing;
      @(posedge core_clk) disable iff (sys_rst)
      s_open_expire |=> !rst_out_q && cause_q[CAUSE_MISS_BIT];
   endproperty
   a_missing: assert property (p_missing) else $error("missing pulse no reset");

   property p_early;
      @(posedge core_clk) disable iff (sys_rst)
      s_closed_trig |=> !rst_out_q && cause_q[CAUSE_EARLY_BIT];
   endproperty
   a_early: assert property (p_early) else $error("early pulse no reset");

   property p_uv;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && uv_out) |=> !rst_out_q && (cnt_q == CNT_ZERO);
   endproperty
   a_uv: assert property (p_uv) else $error("undervoltage no reset");

   property p_suspend;
      @(posedge core_clk) disable iff (sys_rst)
      (clk_en && low_load && !uv_any && (state_q != ST_RESET)) |=> (state_q == ST_OFF);
   endproperty
   a_suspend: assert property (p_suspend) else $error("low load not suspended");
endmodule

// ==== tb/wwd_host_model.sv ====
// Purpose: Host side of the watchdog link, pulses the trigger line
// Assumes: Line idles high, each pulse stays low for three sample periods
// Notes: hold_low parks the line low for edge-direction tests
`timescale 1ns/1ps
module wwd_host_model #(
   parameter int SP = 8
)(
   input wire logic core_clk,
   input wire logic fire,
   input wire logic hold_low,
   output logic wd_trigger_in
);
   // Cycles left in the current low pulse
   int low_q = 0;
   // Three ticks low so two low samples always land
   always @(posedge core_clk)
   begin
      if (fire)
      begin
         low_q <= 3 * SP;
      end
      else if (low_q != 0)
      begin
         low_q <= low_q - 1;
      end
   end
   // Idle high gives the two high samples ahead of each fall
   assign wd_trigger_in = !(hold_low || low_q != 0);
endmodule

// ==== tb/test_window_watchdog_reset.sv ====
// Purpose: Self-checking bench for the window watchdog
// Assumes: Sample period shortened to 8 cycles, fast windows 64 ticks, long window 256
// Notes: Durations are judged in ticks rounded from cycle counts
`timescale 1ns/1ps
module test_window_watchdog_reset;
   import wwd_pkg::*;
   localparam int SP = 8;
   // Stimulus and observed signals
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic mode_sel_1 = 1'b0;
   logic mode_sel_2 = 1'b0;
   logic uv_out = 1'b0;
   logic uv_in = 1'b0;
   logic uv_in_enable = 1'b0;
   logic low_load = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 8'h00;
   logic [DATA_W-1:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic reset_out_n;
   logic wd_trigger_in;
   logic fire = 1'b0;
   logic hold_low = 1'b0;
   logic clk_en = 1'b1; // Low freezes the design
   // Verdict counters
   int bad_count = 0;
   int n_tests = 0;
   // 200 MHz clock
   always #2.5 core_clk = ~core_clk;
   // Device under test
   window_watchdog_reset #(.SAMPLE_PERIOD(SP)) dut_u (
      .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .wd_trigger_in(wd_trigger_in), .mode_sel_1(mode_sel_1), .mode_sel_2(mode_sel_2),
      .uv_out(uv_out), .uv_in(uv_in), .uv_in_enable(uv_in_enable), .low_load(low_load),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reset_out_n(reset_out_n)
   );
   // Host model on the trigger line
   wwd_host_model #(.SP(SP)) host_u (
      .core_clk(core_clk), .fire(fire), .hold_low(hold_low), .wd_trigger_in(wd_trigger_in)
   );
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   // Verdict and end of run
   task automatic summarize();
      if (bad_count == 0 && n_tests > 0)
      begin
         $display("Result: passed");
      end
      else
      begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Cycles to nearest tick
   function automatic int tk(input int n);
      return (n + SP / 2) / SP;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // One-cycle read, data taken in the following cycle
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   // One-cycle write
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // One trigger pulse from the host
   task automatic pulse();
      @(posedge core_clk);
      fire <= 1'b1;
      @(posedge core_clk);
      fire <= 1'b0;
   endtask
   // Poll the state field, bounded
   task automatic wait_st(input logic [2:0] s, output int n);
      logic [DATA_W-1:0] d;
      n = 0;
      d = DATA_ZERO;
      while (d[2:0] !== s && n < 6000)
      begin
         rd(OFF_STATUS, d);
         n += 2;
      end
      chk("state", d[2:0], s);
   endtask
   // Wait for a reset output level, bounded
   task automatic wait_rst(input logic v, output int n);
      n = 0;
      while (reset_out_n !== v && n < 9000)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk("reset level", reset_out_n, v);
   endtask
   // Reset with given straps and check the delay
   task automatic boot(input logic s1, input logic s2);
      int n;
      @(posedge core_clk);
      mode_sel_1 <= s1;
      mode_sel_2 <= s2;
      sys_rst <= 1'b1;
      cyc(6);
      sys_rst <= 1'b0;
      wait_rst(1'b1, n);
      chk("reset delay", tk(n), (s1 || s2) ? 64 : 32);
   endtask
   // All strap combinations, status bits, unmapped read
   task automatic t_modes();
      logic [DATA_W-1:0] d;
      for (int i = 0; i < 4; i++)
      begin
         boot(i[1], i[0]);
         rd(OFF_STATUS, d);
         chk("slow bit", d[STAT_SLOW_BIT], i == 1);
         chk("off bit", d[STAT_OFF_BIT], i == 3);
         chk("mode state", d[2:0], (i == 3) ? ST_OFF : ST_IGNORE);
      end
      rd(8'h10, d);
      chk("unmapped", d, DATA_ZERO);
   endtask
   // Triggers ignored, ignore window length, fast and slow
   task automatic t_ignore(input logic s2);
      int n;
      boot(1'b0, s2);
      cyc(10 * SP);
      pulse();
      wait_st(ST_LONG, n);
      chk("ignore ticks", tk(n + 10 * SP + 2), s2 ? 128 : 64);
      chk("ignore rst", reset_out_n, 1'b1);
   endtask
   // Long -> closed -> open -> closed, then early pulse
   task automatic t_cycle();
      int n;
      logic [DATA_W-1:0] d;
      boot(1'b0, 1'b0);
      wait_st(ST_LONG, n);
      // History starts low, two high samples first
      cyc(2 * SP);
      pulse();
      wait_st(ST_CLOSED, n);
      chk("long trig", n <= 3 * SP, 1'b1);
      wait_st(ST_OPEN, n);
      chk("closed ticks", tk(n), 64);
      cyc(10 * SP);
      pulse();
      wait_st(ST_CLOSED, n);
      chk("open ends", n <= 3 * SP, 1'b1);
      cyc(10 * SP);
      pulse();
      wait_rst(1'b0, n);
      chk("early lag", n <= 3 * SP, 1'b1);
      // Delay counted from the reset edge itself
      wait_rst(1'b1, n);
      chk("redelay", tk(n), 32);
      rd(OFF_CAUSE, d);
      chk("early cause", d[CAUSE_EARLY_BIT], 1'b1);
      wr(OFF_CAUSE, 32'h0000_0002);
      rd(OFF_CAUSE, d);
      chk("cause clr", d, DATA_ZERO);
      wait_st(ST_IGNORE, n);
   endtask
   // Missing pulse in standard open window
   task automatic t_missing();
      int n;
      logic [DATA_W-1:0] d;
      boot(1'b0, 1'b0);
      wait_st(ST_LONG, n);
      cyc(2 * SP);
      pulse();
      wait_st(ST_CLOSED, n);
      wait_st(ST_OPEN, n);
      wait_rst(1'b0, n);
      chk("open ticks", tk(n), 64);
      rd(OFF_CAUSE, d);
      chk("miss cause", d[CAUSE_MISS_BIT], 1'b1);
   endtask
   // Rising edge only in long window, long window runs out
   task automatic t_long_edge();
      int n;
      hold_low <= 1'b1;
      boot(1'b0, 1'b0);
      wait_st(ST_LONG, n);
      hold_low <= 1'b0;
      wait_rst(1'b0, n);
      chk("long ticks", tk(n), 256);
   endtask
   // Undervoltage inputs force reset
   task automatic t_uv();
      int n;
      logic [DATA_W-1:0] d;
      boot(1'b0, 1'b0);
      uv_out <= 1'b1;
      cyc(3);
      chk("uv out", reset_out_n, 1'b0);
      cyc(40 * SP);
      uv_out <= 1'b0;
      wait_rst(1'b1, n);
      chk("uv delay", tk(n), 32);
      rd(OFF_CAUSE, d);
      chk("uv cause", d[CAUSE_UV_BIT], 1'b1);
      uv_in <= 1'b1;
      cyc(3);
      chk("uv in off", reset_out_n, 1'b1);
      uv_in_enable <= 1'b1;
      cyc(3);
      chk("uv in on", reset_out_n, 1'b0);
      uv_in <= 1'b0;
      uv_in_enable <= 1'b0;
   endtask
   // Low load suspends, release restarts at ignore
   task automatic t_low_load();
      int n;
      logic [DATA_W-1:0] d;
      boot(1'b0, 1'b0);
      wait_st(ST_LONG, n);
      low_load <= 1'b1;
      wait_st(ST_OFF, n);
      rd(OFF_STATUS, d);
      chk("susp bit", d[STAT_SUSP_BIT], 1'b1);
      cyc(300 * SP);
      chk("susp rst", reset_out_n, 1'b1);
      low_load <= 1'b0;
      wait_st(ST_IGNORE, n);
      chk("rearm rst", reset_out_n, 1'b1);
   endtask
   // Clock enable low freezes all, undervoltage unseen
   task automatic t_freeze();
      logic [DATA_W-1:0] d;
      boot(1'b0, 1'b0);
      clk_en <= 1'b0;
      uv_out <= 1'b1;
      cyc(20 * SP);
      chk("frozen rst", reset_out_n, 1'b1);
      uv_out <= 1'b0;
      clk_en <= 1'b1;
      rd(OFF_STATUS, d);
      chk("frozen state", d[2:0], ST_IGNORE);
      rd(OFF_CAUSE, d);
      chk("frozen cause", d, DATA_ZERO);
   endtask
   // Bounded run time
   initial
   begin
      #400000;
      bad_count++;
      summarize();
   end
   // Main sequence
   initial
   begin
      t_modes();
      t_ignore(1'b0);
      t_ignore(1'b1);
      t_cycle();
      t_missing();
      t_long_edge();
      t_uv();
      t_low_load();
      t_freeze();
      summarize();
   end
endmodule
